/* shared/exec_pkg.sv */
/*
 * Shared constants and types for the logic, shift and branch execution unit.
 * Assumes a single 125 MHz core clock and an 8-bit data path.
 */
`default_nettype none

package exec_pkg;

    // ========================================================================
    // Widths
    localparam int WORD_W = 8;
    localparam int ADDR_W = 7;
    localparam int LIT_W = 9;
    localparam int BIT_W = 3;
    localparam int PC_W_DEFAULT = 15;
    localparam int FILE_DEPTH = 128;

    // ========================================================================
    // Field positions
    localparam int WORD_MSB = 7;
    localparam int LIT_SIGN = 8;

    // ========================================================================
    // Values after reset
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic ZERO_RESET = 1'b0;
    localparam logic CARRY_RESET = 1'b0;
    localparam logic [7:0] RD_RESET = 8'h00;

    // ========================================================================
    // Operations
    typedef enum logic [3:0] {
        OP_NOP      = 4'h0,
        OP_AND_LIT  = 4'h1,
        OP_AND_FILE = 4'h2,
        OP_ASR_FILE = 4'h3,
        OP_BIT_CLR  = 4'h4,
        OP_BIT_SET  = 4'h5,
        OP_JUMP_LIT = 4'h6,
        OP_JUMP_ACC = 4'h7,
        OP_SKIP_CLR = 4'h8
    } op_t;

    // ========================================================================
    // Sequencer, two clocks per instruction cycle
    typedef enum logic [1:0] {
        ST_READ  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_NOP_A = 2'b11,
        ST_NOP_B = 2'b10
    } state_t;

endpackage : exec_pkg

`default_nettype wire

/* shared/file_bus_if.sv */
/*
 * Port between the execution unit and its file register memory.
 * Assumes all signals live on the core clock.
 */
`default_nettype none

interface file_bus_if #(
    parameter int ADDR_W = 7,
    parameter int DATA_W = 8
);
    logic [ADDR_W-1:0] addr;
    logic wr_en;
    logic [DATA_W-1:0] wr_data;
    logic [DATA_W-1:0] rd_data;

    modport master (output addr, output wr_en, output wr_data, input rd_data);
    modport mem (input addr, input wr_en, input wr_data, output rd_data);
endinterface : file_bus_if

`default_nettype wire

/* verilog/file_regs.sv */
/*
 * File register memory with registered read data.
 * Assumes one read address per enabled clock and writes from one master.
 */
`default_nettype none

module file_regs
    import exec_pkg::*;
#(
    parameter int DEPTH = FILE_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // Memory port
    file_bus_if.mem bus
);

    // ========================================================================
    // Storage
    logic [WORD_W-1:0] mem [DEPTH];
    logic [WORD_W-1:0] rd_data;
    logic [WORD_W-1:0] next_rd_data;

    always_comb begin
        next_rd_data = ce ? mem[bus.addr] : rd_data;
    end

    always_ff @(posedge clk) begin
        if (ce && bus.wr_en) begin
            mem[bus.addr] <= bus.wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= RD_RESET;
        end else begin
            rd_data <= next_rd_data;
        end
    end

    assign bus.rd_data = rd_data;

endmodule : file_regs

`default_nettype wire

/* verilog/exec_alu.sv */
/*
 * Combinational data path for AND, arithmetic shift and bit operations.
 * Assumes operands are stable for the execute clock.
 */
`default_nettype none

module exec_alu
    import exec_pkg::*;
(
    // Operands
    input wire op_t op,
    input wire logic [WORD_W-1:0] acc,
    input wire logic [WORD_W-1:0] file_data,
    input wire logic [WORD_W-1:0] lit,
    input wire logic [BIT_W-1:0] bit_sel,
    input wire logic dest,
    // Results
    output logic [WORD_W-1:0] result,
    output logic zero,
    output logic carry,
    output logic wr_acc,
    output logic wr_file,
    output logic upd_zero,
    output logic upd_carry,
    output logic skip
);

    // ========================================================================
    // Operation decode
    always_comb begin
        result = file_data;
        carry = 1'b0;
        wr_acc = 1'b0;
        wr_file = 1'b0;
        upd_zero = 1'b0;
        upd_carry = 1'b0;
        skip = 1'b0;
        case (op)
            OP_AND_LIT: begin
                result = acc & lit;
                wr_acc = 1'b1;
                upd_zero = 1'b1;
            end
            OP_AND_FILE: begin
                result = acc & file_data;
                wr_acc = !dest;
                wr_file = dest;
                upd_zero = 1'b1;
            end
            OP_ASR_FILE: begin
                result = {file_data[WORD_MSB], file_data[WORD_MSB:1]};
                carry = file_data[0];
                upd_carry = 1'b1;
                upd_zero = 1'b1;
                wr_acc = !dest;
                wr_file = dest;
            end
            OP_BIT_CLR: begin
                result[bit_sel] = 1'b0;
                wr_file = 1'b1;
            end
            OP_BIT_SET: begin
                result[bit_sel] = 1'b1;
                wr_file = 1'b1;
            end
            OP_SKIP_CLR: begin
                skip = !file_data[bit_sel];
            end
            default: begin
                result = file_data;
            end
        endcase
        zero = (result == '0);
    end

endmodule : exec_alu

`default_nettype wire

/* verilog/exec_core.sv */
/*
 * Execution unit for AND, arithmetic shift, bit clear/set, relative jumps
 * and skip-if-bit-clear, with accumulator, zero and carry flags and the
 * file register memory.
 * Assumes the fetch stage presents one instruction with INSTR_VALID on the
 * core clock, holds it until READY accepts it, and supplies PC_INC (the
 * already incremented program counter of that instruction).
 */
//
// Contract
// - AND with literal stores accumulator AND an 8-bit literal in accumulator, updates zero only.
// - AND with file ANDs accumulator with a file register, result to accumulator (dest 0) or file (dest 1), zero only.
// - Arithmetic shift right moves bit 0 to carry and bits 7:1 to 6:0, updating carry and zero.
// - Arithmetic shift right keeps the original top bit as the result's top bit.
// - Arithmetic shift right result goes to accumulator for dest 0 and to the file register for dest 1.
// - Bit clear forces the indexed bit of the file register to zero and changes no flag.
// - Bit set forces the indexed bit of the file register to one and changes no flag.
// - Relative jump by literal loads PC with incremented PC plus signed 9-bit offset, two cycles, no flags.
// - Relative jump by accumulator loads PC with incremented PC plus unsigned accumulator, two cycles, no flags.
// - Skip with tested bit zero discards the fetched next instruction and runs a no-op, two cycles.
// - Skip with tested bit one lets the next instruction run normally, no flag changes.
// - An instruction that changes the PC or passes its test takes two cycles, the second a no-op.
`default_nettype none

module exec_core
    import exec_pkg::*;
#(
    parameter int PC_WIDTH = PC_W_DEFAULT
) (
    // Clock, reset and enable
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // Instruction from fetch and decode
    input wire logic INSTR_VALID,
    input wire op_t OP,
    input wire logic [ADDR_W-1:0] FILE_ADDR,
    input wire logic [LIT_W-1:0] LITERAL,
    input wire logic [BIT_W-1:0] BIT_INDEX,
    input wire logic DEST,
    input wire logic [PC_WIDTH-1:0] PC_INC,
    // Handshake and completion
    output logic READY,
    output logic INSTR_DONE,
    // Program counter control
    output logic PC_LOAD,
    output logic [PC_WIDTH-1:0] PC_TARGET,
    output logic DISCARD_NEXT,
    // Architectural state
    output logic [WORD_W-1:0] ACCUMULATOR,
    output logic ZERO_FLAG,
    output logic CARRY_FLAG
);

    // ========================================================================
    // Declarations
    state_t state;
    state_t next_state;
    op_t op_q;
    op_t next_op_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] next_addr_q;
    logic [LIT_W-1:0] lit_q;
    logic [LIT_W-1:0] next_lit_q;
    logic [BIT_W-1:0] bit_q;
    logic [BIT_W-1:0] next_bit_q;
    logic dest_q;
    logic next_dest_q;
    logic [PC_WIDTH-1:0] pc_q;
    logic [PC_WIDTH-1:0] next_pc_q;

    logic [WORD_W-1:0] acc;
    logic [WORD_W-1:0] next_acc;
    logic zero;
    logic next_zero;
    logic carry;
    logic next_carry;
    logic ready;
    logic next_ready;
    logic done;
    logic next_done;
    logic pc_load;
    logic next_pc_load;
    logic [PC_WIDTH-1:0] pc_target;
    logic [PC_WIDTH-1:0] next_pc_target;
    logic discard;
    logic next_discard;

    logic [WORD_W-1:0] alu_result;
    logic alu_zero;
    logic alu_carry;
    logic alu_wr_acc;
    logic alu_wr_file;
    logic alu_upd_zero;
    logic alu_upd_carry;
    logic alu_skip;
    logic take;
    logic is_jump;
    logic [PC_WIDTH-1:0] jump_lit;
    logic [PC_WIDTH-1:0] jump_acc;

    file_bus_if #(.ADDR_W(ADDR_W), .DATA_W(WORD_W)) fbus ();

    // ========================================================================
    // File register memory and data path
    file_regs #(
        .DEPTH(FILE_DEPTH)
    ) u_file_regs (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .bus(fbus.mem)
    );

    exec_alu u_alu (
        .op(op_q),
        .acc(acc),
        .file_data(fbus.rd_data),
        .lit(lit_q[WORD_W-1:0]),
        .bit_sel(bit_q),
        .dest(dest_q),
        .result(alu_result),
        .zero(alu_zero),
        .carry(alu_carry),
        .wr_acc(alu_wr_acc),
        .wr_file(alu_wr_file),
        .upd_zero(alu_upd_zero),
        .upd_carry(alu_upd_carry),
        .skip(alu_skip)
    );

    // ========================================================================
    // Memory port: operand read at accept, write back at execute
    assign take = (state == ST_READ) && INSTR_VALID;
    assign fbus.addr = (state == ST_READ) ? FILE_ADDR : addr_q;
    assign fbus.wr_en = (state == ST_EXEC) && alu_wr_file;
    assign fbus.wr_data = alu_result;

    // ========================================================================
    // Branch targets
    assign is_jump = (op_q == OP_JUMP_LIT) || (op_q == OP_JUMP_ACC);
    assign jump_lit = pc_q
        + {{(PC_WIDTH - LIT_W){lit_q[LIT_SIGN]}}, lit_q};
    assign jump_acc = pc_q
        + {{(PC_WIDTH - WORD_W){1'b0}}, acc};

    // ========================================================================
    // Instruction latch and sequencer
    always_comb begin
        next_state = state;
        next_op_q = op_q;
        next_addr_q = addr_q;
        next_lit_q = lit_q;
        next_bit_q = bit_q;
        next_dest_q = dest_q;
        next_pc_q = pc_q;
        case (state)
            ST_READ: begin
                if (take) begin
                    next_op_q = OP;
                    next_addr_q = FILE_ADDR;
                    next_lit_q = LITERAL;
                    next_bit_q = BIT_INDEX;
                    next_dest_q = DEST;
                    next_pc_q = PC_INC;
                    next_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                if (is_jump || alu_skip) begin
                    next_state = ST_NOP_A;
                end else begin
                    next_state = ST_READ;
                end
            end
            ST_NOP_A: begin
                next_state = ST_NOP_B;
            end
            ST_NOP_B: begin
                next_state = ST_READ;
            end
            default: begin
                next_state = ST_READ;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ST_READ;
            op_q <= OP_NOP;
            addr_q <= '0;
            lit_q <= '0;
            bit_q <= '0;
            dest_q <= 1'b0;
            pc_q <= '0;
        end else if (CE) begin
            state <= next_state;
            op_q <= next_op_q;
            addr_q <= next_addr_q;
            lit_q <= next_lit_q;
            bit_q <= next_bit_q;
            dest_q <= next_dest_q;
            pc_q <= next_pc_q;
        end
    end

    // ========================================================================
    // Accumulator, flags and fetch control
    always_comb begin
        next_acc = acc;
        next_zero = zero;
        next_carry = carry;
        next_pc_load = 1'b0;
        next_pc_target = pc_target;
        next_discard = 1'b0;
        next_done = 1'b0;
        if (state == ST_EXEC) begin
            if (alu_wr_acc) begin
                next_acc = alu_result;
            end
            if (alu_upd_zero) begin
                next_zero = alu_zero;
            end
            if (alu_upd_carry) begin
                next_carry = alu_carry;
            end
            if (op_q == OP_JUMP_LIT) begin
                next_pc_load = 1'b1;
                next_pc_target = jump_lit;
            end else if (op_q == OP_JUMP_ACC) begin
                next_pc_load = 1'b1;
                next_pc_target = jump_acc;
            end
            next_discard = alu_skip;
            next_done = !(is_jump || alu_skip);
        end else if (state == ST_NOP_B) begin
            next_done = 1'b1;
        end
        next_ready = (next_state == ST_READ);
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            acc <= ACC_RESET;
            zero <= ZERO_RESET;
            carry <= CARRY_RESET;
            ready <= 1'b1;
            done <= 1'b0;
            pc_load <= 1'b0;
            pc_target <= '0;
            discard <= 1'b0;
        end else if (CE) begin
            acc <= next_acc;
            zero <= next_zero;
            carry <= next_carry;
            ready <= next_ready;
            done <= next_done;
            pc_load <= next_pc_load;
            pc_target <= next_pc_target;
            discard <= next_discard;
        end
    end

    // ========================================================================
    // Outputs
    assign READY = ready;
    assign INSTR_DONE = done;
    assign PC_LOAD = pc_load;
    assign PC_TARGET = pc_target;
    assign DISCARD_NEXT = discard;
    assign ACCUMULATOR = acc;
    assign ZERO_FLAG = zero;
    assign CARRY_FLAG = carry;

endmodule : exec_core

`default_nettype wire

/* verif/exec_core_asserts.sv */
/*
 * Port checks of the execution unit.
 * Assumes binding to exec_core by the statement after the module.
 */
`default_nettype none

module exec_core_asserts
    import exec_pkg::*;
#(
    parameter int PC_WIDTH = PC_W_DEFAULT
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CE,
    // Instruction
    input wire logic INSTR_VALID,
    input wire op_t OP,
    input wire logic [LIT_W-1:0] LITERAL,
    input wire logic DEST,
    input wire logic [PC_WIDTH-1:0] PC_INC,
    // Results
    input wire logic READY,
    input wire logic INSTR_DONE,
    input wire logic PC_LOAD,
    input wire logic [PC_WIDTH-1:0] PC_TARGET,
    input wire logic DISCARD_NEXT,
    input wire logic [WORD_W-1:0] ACCUMULATOR,
    input wire logic ZERO_FLAG,
    input wire logic CARRY_FLAG
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================
    // Helpers
    logic take;
    logic [PC_WIDTH-1:0] lit_tgt;
    logic [PC_WIDTH-1:0] acc_tgt;
    assign take = CE && READY && INSTR_VALID;
    assign lit_tgt = PC_INC + PC_WIDTH'($signed(LITERAL));
    assign acc_tgt = PC_INC + PC_WIDTH'(ACCUMULATOR);

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    // ========================================
    // Instruction lengths
    sequence s_one;
        !READY ##1 (READY && INSTR_DONE);
    endsequence
    sequence s_two;
        !READY [*3] ##1 (READY && INSTR_DONE);
    endsequence
    sequence s_skipped;
        DISCARD_NEXT && !READY ##1 !READY ##1 (READY && INSTR_DONE);
    endsequence

    // ========================================
    // Checks
    a_and_lit_value: assert property (take && OP == OP_AND_LIT |-> ##2
        ACCUMULATOR == 8'($past(ACCUMULATOR, 2) & $past(LITERAL, 2)))
        else $error("and literal result");
    a_acc_zero_match: assert property (take && (OP == OP_AND_LIT
        || !DEST && OP inside {OP_AND_FILE, OP_ASR_FILE})
        |-> ##2 ZERO_FLAG == (ACCUMULATOR == 8'h00))
        else $error("zero flag");
    a_asr_sign_kept: assert property (take && OP == OP_ASR_FILE && !DEST
        |-> ##2 ACCUMULATOR[WORD_MSB] == ACCUMULATOR[WORD_MSB-1])
        else $error("shift sign");
    a_file_dest_hold: assert property (take && DEST
        && OP inside {OP_AND_FILE, OP_ASR_FILE}
        |-> ##2 ACCUMULATOR == $past(ACCUMULATOR, 2))
        else $error("accumulator written");
    a_carry_kept: assert property (take && OP inside {OP_AND_LIT,
        OP_AND_FILE, OP_BIT_CLR, OP_BIT_SET, OP_JUMP_LIT, OP_JUMP_ACC,
        OP_SKIP_CLR} |-> ##2 CARRY_FLAG == $past(CARRY_FLAG, 2))
        else $error("carry changed");
    a_zero_acc_kept: assert property (take && OP inside {OP_BIT_CLR,
        OP_BIT_SET, OP_JUMP_LIT, OP_JUMP_ACC, OP_SKIP_CLR} |-> ##2
        ZERO_FLAG == $past(ZERO_FLAG, 2)
        && ACCUMULATOR == $past(ACCUMULATOR, 2))
        else $error("zero or accumulator changed");
    a_jump_lit_dest: assert property (take && OP == OP_JUMP_LIT |-> ##2
        PC_LOAD && PC_TARGET == $past(lit_tgt, 2))
        else $error("literal jump target");
    a_jump_acc_dest: assert property (take && OP == OP_JUMP_ACC |-> ##2
        PC_LOAD && PC_TARGET == $past(acc_tgt, 2))
        else $error("accumulator jump target");
    a_jump_two_cycles: assert property (take && OP inside {OP_JUMP_LIT,
        OP_JUMP_ACC} |=> s_two)
        else $error("jump length");
    a_short_one_cycle: assert property (take && OP inside {OP_AND_LIT,
        OP_AND_FILE, OP_ASR_FILE, OP_BIT_CLR, OP_BIT_SET} |=> s_one)
        else $error("single cycle length");
    a_skip_outcome: assert property (take && OP == OP_SKIP_CLR |-> ##2
        (INSTR_DONE && !DISCARD_NEXT) or s_skipped)
        else $error("skip outcome");
endmodule : exec_core_asserts

bind exec_core exec_core_asserts #(.PC_WIDTH(PC_WIDTH)) u_exec_core_asserts (
    .CLK(CLK), .RST_N(RST_N), .CE(CE), .INSTR_VALID(INSTR_VALID), .OP(OP),
    .LITERAL(LITERAL), .DEST(DEST), .PC_INC(PC_INC), .READY(READY),
    .INSTR_DONE(INSTR_DONE), .PC_LOAD(PC_LOAD), .PC_TARGET(PC_TARGET),
    .DISCARD_NEXT(DISCARD_NEXT), .ACCUMULATOR(ACCUMULATOR),
    .ZERO_FLAG(ZERO_FLAG), .CARRY_FLAG(CARRY_FLAG)
);

`default_nettype wire

/* verif/fetch_model.sv */
/*
 * Fetch stage model offering one instruction at a time.
 * Assumes the execution unit's handshake on the core clock.
 */
`default_nettype none

module fetch_model
    import exec_pkg::*;
#(
    parameter int PC_WIDTH = PC_W_DEFAULT
) (
    // Clock and handshake
    input wire logic clk,
    input wire logic ready,
    input wire logic done,
    input wire logic pc_load,
    input wire logic discard,
    // Instruction
    output logic valid,
    output var op_t op,
    output logic [ADDR_W-1:0] addr,
    output logic [LIT_W-1:0] lit,
    output logic [BIT_W-1:0] bidx,
    output logic dest,
    output logic [PC_WIDTH-1:0] pc_inc
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        valid = 1'b0;
        op = OP_NOP;
        {addr, lit, bidx, dest, pc_inc} = '0;
    end

    // ========================================
    // Offer, hold until taken, then time the instruction
    task automatic issue(input op_t o, input logic [ADDR_W-1:0] a,
        input logic [LIT_W-1:0] k, input logic [BIT_W-1:0] b,
        input logic d, input logic [PC_WIDTH-1:0] pc, output int n,
        output logic pl, output logic dn);
        n = 0;
        pl = 1'b0;
        dn = 1'b0;
        op = o;
        {addr, lit, bidx, dest, pc_inc} = {a, k, b, d, pc};
        valid = 1'b1;
        while (ready !== 1'b1 && n < 16) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        valid = 1'b0;
        op = OP_NOP;
        {addr, lit, bidx, dest, pc_inc} = ~{a, k, b, d, pc};
        n = 0;
        while (done !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
            pl = pl | pc_load;
            dn = dn | discard;
        end
    endtask : issue
endmodule : fetch_model

`default_nettype wire

/* verif/tb_top.sv */
/*
 * Self-checking bench of the execution unit with a reference model.
 * Assumes the checker binds itself and the fetch model drives inputs.
 */
`default_nettype none

module tb_top
    import exec_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PCW = PC_W_DEFAULT;

    logic clk, rst_n, ce, valid, dest, ready, done, pc_load, discard;
    logic zero, carry, z_m, c_m;
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [LIT_W-1:0] lit;
    logic [BIT_W-1:0] bidx;
    logic [PCW-1:0] pc_inc, target;
    logic [7:0] acc, acc_m;
    logic [7:0] mem [FILE_DEPTH];
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;

    exec_core u_exec_core (.CLK(clk), .RST_N(rst_n), .CE(ce),
        .INSTR_VALID(valid), .OP(op), .FILE_ADDR(addr), .LITERAL(lit),
        .BIT_INDEX(bidx), .DEST(dest), .PC_INC(pc_inc), .READY(ready),
        .INSTR_DONE(done), .PC_LOAD(pc_load), .PC_TARGET(target),
        .DISCARD_NEXT(discard), .ACCUMULATOR(acc), .ZERO_FLAG(zero),
        .CARRY_FLAG(carry));
    fetch_model u_fetch_model (.clk(clk), .ready(ready), .done(done),
        .pc_load(pc_load), .discard(discard), .valid(valid), .op(op),
        .addr(addr), .lit(lit), .bidx(bidx), .dest(dest), .pc_inc(pc_inc));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ========================================
    // Reporting
    task automatic check(input string name, input logic [31:0] seen,
        input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check

    task automatic conclude;
        if (n_fail == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            conclude();
        end
    end

    // ========================================
    // Reference model
    function automatic logic [7:0] shr_keep(input logic [7:0] f);
        return {f[7], f[7:1]};
    endfunction : shr_keep

    task automatic run(input op_t o, input logic [ADDR_W-1:0] a,
        input logic [LIT_W-1:0] k, input logic [BIT_W-1:0] b, input logic d);
        logic [7:0] f;
        logic [7:0] r;
        logic [PCW-1:0] pc;
        logic [PCW-1:0] tgt;
        logic pl, dn, ep, ed;
        int n;
        pc = PCW'($urandom);
        f = mem[a];
        r = 8'h00;
        tgt = '0;
        ed = 1'b0;
        case (o)
            OP_AND_LIT: r = acc_m & k[7:0];
            OP_AND_FILE: r = acc_m & f;
            OP_ASR_FILE: begin
                r = shr_keep(f);
                c_m = f[0];
            end
            OP_BIT_CLR: mem[a][b] = 1'b0;
            OP_BIT_SET: mem[a][b] = 1'b1;
            OP_JUMP_LIT: tgt = pc + PCW'($signed(k));
            OP_JUMP_ACC: tgt = pc + PCW'(acc_m);
            OP_SKIP_CLR: ed = ~f[b];
            default: ed = 1'b0;
        endcase
        if (o inside {OP_AND_LIT, OP_AND_FILE, OP_ASR_FILE}) begin
            z_m = (r == 8'h00);
            if (d && o != OP_AND_LIT) mem[a] = r;
            else acc_m = r;
        end
        ep = (o inside {OP_JUMP_LIT, OP_JUMP_ACC});
        u_fetch_model.issue(o, a, k, b, d, pc, n, pl, dn);
        check("cycles", n, (ep || ed) ? 3 : 1);
        check("accumulator", acc, acc_m);
        check("zero", zero, z_m);
        check("carry", carry, c_m);
        check("pc_load", pl, ep);
        check("discard", dn, ed);
        if (ep) check("target", target, tgt);
    endtask : run

    // ========================================
    // Main sequence
    initial begin
        void'($urandom(32'h002a495d));
        rst_n = 1'b0;
        ce = 1'b1;
        {acc_m, z_m, c_m} = '0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        check("ready", ready, 1'b1);
        check("target", target, '0);
        for (int i = 0; i < 17; i++)
            for (int j = 0; j < 8; j++)
                run((i == 16 || $urandom_range(1) == 1) ? OP_BIT_SET
                    : OP_BIT_CLR, (i == 16) ? 7'h7f : 7'(i), '0, 3'(j), 1'b0);
        run(OP_ASR_FILE, 7'h7f, '0, 3'h0, 1'b0);
        run(OP_JUMP_ACC, 7'h00, '0, 3'h0, 1'b0);
        run(OP_JUMP_LIT, 7'h00, 9'h100, 3'h0, 1'b0);
        run(OP_JUMP_LIT, 7'h00, 9'h0ff, 3'h0, 1'b0);
        run(OP_SKIP_CLR, 7'h7f, '0, 3'h7, 1'b0);
        run(OP_BIT_CLR, 7'h7f, '0, 3'h7, 1'b0);
        run(OP_SKIP_CLR, 7'h7f, '0, 3'h7, 1'b0);
        run(OP_AND_LIT, 7'h00, 9'h100, 3'h0, 1'b0);
        run(OP_NOP, 7'h7f, 9'h0ff, 3'h7, 1'b1);
        ce = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("done frozen", done, 1'b1);
        check("ready frozen", ready, 1'b1);
        check("zero frozen", zero, 1'b1);
        ce = 1'b1;
        for (int i = 0; i < 300; i++)
            run(op_t'($urandom_range(8, 1)), ($urandom_range(3) == 0)
                ? 7'h7f : 7'($urandom_range(15)), 9'($urandom),
                3'($urandom), 1'($urandom));
        conclude();
    end
endmodule : tb_top

`default_nettype wire
